// ==== hw/acrd_top.sv ====
// Purpose: master clock select, prescale, sample and output rate dividers
// Assumes: master clock pins well below half of i_clk_sys
// Notes: slower clocks are one-cycle enables on i_clk_sys
`timescale 1ns/1ps
`include "acrd_defines.svh"
module acrd_top #(
	parameter int NCH = 6,
	parameter int MOD_W = 4
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_crystal_clk,
	input wire logic i_ext_clk,
	input wire logic i_clock_source_external,
	input wire acrd_pkg::acrd_pre_t i_prescale_select,
	input wire acrd_pkg::acrd_osr_t i_oversampling_select,
	input wire logic i_ready_pin_drive_mode,
	input wire logic [NCH*MOD_W-1:0] i_mod_samples,
	input wire logic [NCH*24-1:0] i_offset_trim_word,
	input wire logic [NCH*24-1:0] i_gain_trim_word,
	output logic [NCH*24-1:0] o_results,
	output logic o_analog_modulator_clock,
	output logic o_digital_sample_clock,
	output logic o_output_rate_clock,
	output logic o_result_ready_n,
	output logic o_result_ready_n_oe
);
	import acrd_pkg::*;
	logic [1:0] rst_sync_r;
	logic rst_n;
	logic [2:0] pin_s1_r;
	logic [2:0] pin_s2_r;
	logic [2:0] pin_s3_r;
	logic [1:0] pin_rise;
	logic master_tick;
	logic [2:0] pre_cnt_r;
	logic [2:0] pre_last;
	logic analog_modulator_clock_tick;
	logic [1:0] quad_cnt_r;
	logic sample_tick;
	logic [11:0] rate_cnt_r;
	logic [12:0] ratio;
	logic [11:0] rate_last;
	logic rate_tick;
	acrd_rdy_e rdy_r;
	acrd_rdy_e rdy_nxt;
	logic low_cnt_r;
	logic src_ext_r;
	// ======================================================================
	// reset release through two flip-flops
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];
	// ======================================================================
	// pin synchronisers for the two master clock sources and the source select pin
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_r <= 3'h0;
			pin_s2_r <= 3'h0;
			pin_s3_r <= 3'h0;
		end else begin
			pin_s1_r <= {i_clock_source_external, i_ext_clk, i_crystal_clk};
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
		end
	end
	// a level only counts once stages two and three agree
	genvar gp;
	generate
		for (gp = 0; gp < 2; gp++) begin : g_pin
			// one filtered level per pin, owned by this block alone
			logic lvl_r;
			always_ff @(posedge i_clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					lvl_r <= 1'b0;
				end else if (pin_s2_r[gp] == pin_s3_r[gp]) begin
					lvl_r <= pin_s3_r[gp];
				end
			end
			assign pin_rise[gp] = (pin_s2_r[gp] == pin_s3_r[gp]) &&
				pin_s3_r[gp] && !lvl_r;
		end
	endgenerate
	// source bit filtered the same way, so a flip never makes half ticks
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			src_ext_r <= `ACRD_SRC_CRYSTAL;
		end else if (pin_s2_r[2] == pin_s3_r[2]) begin
			src_ext_r <= pin_s3_r[2];
		end
	end
	// one enable per master clock rising edge
	assign master_tick = src_ext_r ? pin_rise[1] : pin_rise[0];
	// ======================================================================
	// prescaler: compare with >= so a smaller setting never locks up
	assign pre_last = 3'((4'h1 << i_prescale_select) - 4'h1);
	assign analog_modulator_clock_tick = master_tick && (pre_cnt_r >= pre_last);
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pre_cnt_r <= 3'h0;
		end else if (analog_modulator_clock_tick) begin
			pre_cnt_r <= 3'h0;
		end else if (master_tick) begin
			pre_cnt_r <= pre_cnt_r + 3'h1;
		end
	end
	// ======================================================================
	// fixed divide by four to the sample rate
	assign sample_tick = analog_modulator_clock_tick && (quad_cnt_r == `ACRD_SAMPLE_LAST);
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			quad_cnt_r <= 2'h0;
		end else if (analog_modulator_clock_tick) begin
			quad_cnt_r <= quad_cnt_r + 2'h1;
		end
	end
	// ======================================================================
	// oversampling divider
	assign ratio = 13'(`ACRD_RATIO_BASE) << i_oversampling_select;
	// 4096 needs a thirteenth bit; the counter itself only reaches 4095
	assign rate_last = 12'(ratio - 13'h0001);
	assign rate_tick = sample_tick && (rate_cnt_r >= rate_last);
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rate_cnt_r <= 12'h000;
		end else if (rate_tick) begin
			rate_cnt_r <= 12'h000;
		end else if (sample_tick) begin
			rate_cnt_r <= rate_cnt_r + 12'h001;
		end
	end
	// ======================================================================
	// clock enables brought out registered, one cycle behind the chain
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			o_analog_modulator_clock <= 1'b0;
			o_digital_sample_clock <= 1'b0;
			o_output_rate_clock <= 1'b0;
		end else begin
			o_analog_modulator_clock <= analog_modulator_clock_tick;
			o_digital_sample_clock <= sample_tick;
			o_output_rate_clock <= rate_tick;
		end
	end
	// ======================================================================
	// channels
	genvar gc;
	generate
		for (gc = 0; gc < NCH; gc++) begin : g_chan
			acrd_chan #(
				.MOD_W(MOD_W),
				.ACC_W(MOD_W + 12)
			) u_chan (
				.i_clk_sys(i_clk_sys),
				.i_rst_n(rst_n),
				.i_sample_tick(sample_tick),
				.i_dump(rate_tick),
				.i_mod_sample(i_mod_samples[gc*MOD_W +: MOD_W]),
				.i_offset_trim_word(i_offset_trim_word[gc*24 +: 24]),
				.i_gain_trim_word(i_gain_trim_word[gc*24 +: 24]),
				.o_result(o_results[gc*24 +: 24])
			);
		end
	endgenerate
	// ======================================================================
	// ready pulse: low for two modulator periods, i.e. half a sample period
	always_comb begin
		rdy_nxt = rdy_r;
		unique case (rdy_r)
			ACRD_RDY_IDLE: begin
				if (rate_tick) begin
					rdy_nxt = ACRD_RDY_LOW;
				end
			end
			ACRD_RDY_LOW: begin
				if (analog_modulator_clock_tick && low_cnt_r == `ACRD_READY_LOW_LAST) begin
					rdy_nxt = ACRD_RDY_IDLE;
				end
			end
			default: begin
				rdy_nxt = ACRD_RDY_IDLE;
			end
		endcase
	end
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdy_r <= ACRD_RDY_IDLE;
		end else begin
			rdy_r <= rdy_nxt;
		end
	end
	// modulator ticks counted only after the one that started the pulse
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt_r <= 1'b0;
		end else if (rdy_r == ACRD_RDY_IDLE) begin
			low_cnt_r <= 1'b0;
		end else if (analog_modulator_clock_tick) begin
			low_cnt_r <= low_cnt_r + 1'b1;
		end
	end
	// pin: not latched, no host acknowledge; idle drive follows the mode bit
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			o_result_ready_n <= 1'b1;
			o_result_ready_n_oe <= 1'b0;
		end else begin
			o_result_ready_n <= (rdy_nxt != ACRD_RDY_LOW);
			o_result_ready_n_oe <= (rdy_nxt == ACRD_RDY_LOW) ||
				i_ready_pin_drive_mode;
		end
	end
endmodule // acrd_top

// ==== hw/acrd_defines.svh ====
// Purpose: timing counts and field constants of the clock and rate divider
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef ACRD_DEFINES_SVH
`define ACRD_DEFINES_SVH
// ==========================================================================
// divider chain
`define ACRD_RATIO_BASE 12'h020
`define ACRD_SAMPLE_LAST 2'h3
`define ACRD_READY_LOW_LAST 1'h1
// ==========================================================================
// trim arithmetic, then the reset value of the clock source select
`define ACRD_TRIM_W 24
`define ACRD_GAIN_FRAC 23
`define ACRD_SRC_CRYSTAL 1'h0
`endif

// ==== hw/acrd_pkg.sv ====
// Purpose: shared types of the clock and rate divider
// Assumes: nothing
// Notes: constants live in acrd_defines.svh
package acrd_pkg;
	// ======================================================================
	// setting fields
	typedef logic [1:0] acrd_pre_t;
	typedef logic [2:0] acrd_osr_t;
	typedef logic signed [23:0] acrd_trim_t;
	// ======================================================================
	// ready pin pulse states
	typedef enum logic [1:0] {
		ACRD_RDY_IDLE = 2'b01,
		ACRD_RDY_LOW = 2'b10
	} acrd_rdy_e;
endpackage

// ==== hw/acrd_chan.sv ====
// Purpose: one channel: sinc decimator with offset and gain trim
// Assumes: i_dump only ever rises together with i_sample_tick
// Notes: result saturates to the trim word width
`timescale 1ns/1ps
`include "acrd_defines.svh"
module acrd_chan #(
	parameter int MOD_W = 4,
	parameter int ACC_W = 16
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_sample_tick,
	input wire logic i_dump,
	input wire logic signed [MOD_W-1:0] i_mod_sample,
	input wire acrd_pkg::acrd_trim_t i_offset_trim_word,
	input wire acrd_pkg::acrd_trim_t i_gain_trim_word,
	output logic signed [23:0] o_result
);
	import acrd_pkg::*;
	logic signed [ACC_W-1:0] acc_r;
	logic signed [ACC_W-1:0] sum;
	logic signed [24:0] shifted;
	logic signed [49:0] prod;
	logic signed [25:0] gained;
	logic signed [23:0] result_nxt;
	// ======================================================================
	// accumulate and dump, the first order sinc
	assign sum = acc_r + ACC_W'(i_mod_sample);
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			acc_r <= '0;
		end else if (i_dump) begin
			acc_r <= '0;
		end else if (i_sample_tick) begin
			acc_r <= sum;
		end
	end
	// ======================================================================
	// offset first, then gain as 1 + trim/2^23
	always_comb begin
		shifted = 25'(sum) + 25'(i_offset_trim_word);
		prod = 50'(shifted) * 50'(i_gain_trim_word);
		gained = 26'(shifted) + 26'(prod >>> `ACRD_GAIN_FRAC);
		// clip rather than wrap: a wrap would flip the sign of a full scale
		if (gained > 26'sh07FFFFF) begin
			result_nxt = 24'sh7FFFFF;
		end else if (gained < -26'sh0800000) begin
			result_nxt = -24'sh800000;
		end else begin
			result_nxt = gained[23:0];
		end
	end
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_result <= '0;
		end else if (i_dump) begin
			o_result <= result_nxt;
		end
	end
endmodule // acrd_chan

// ==== sim/acrd_top_chk.sv ====
// Purpose: port-level assertions on the clock and rate divider
// Assumes: master clock slower than a quarter of the system clock
// Notes: bound onto acrd_top from the bench top file
`timescale 1ns/1ps
module acrd_top_chk #(
	parameter int NCH = 6
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_ready_pin_drive_mode,
	input wire logic [NCH*24-1:0] o_results,
	input wire logic o_analog_modulator_clock,
	input wire logic o_digital_sample_clock,
	input wire logic o_output_rate_clock,
	input wire logic o_result_ready_n,
	input wire logic o_result_ready_n_oe
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	// ======================================================================
	// divider chain nesting
	chk_sample_on_mod: assert property (
		o_digital_sample_clock |-> o_analog_modulator_clock)
		else $error("sample tick without modulator tick");
	chk_rate_on_sample: assert property (
		o_output_rate_clock |-> o_digital_sample_clock)
		else $error("rate tick without sample tick");
	chk_mod_one_cyc: assert property (
		o_analog_modulator_clock |=> !o_analog_modulator_clock)
		else $error("modulator tick longer than one cycle");
	chk_rate_one_cyc: assert property (
		o_output_rate_clock |=> !o_output_rate_clock)
		else $error("rate tick longer than one cycle");
	// ======================================================================
	// ready pin
	chk_ready_starts: assert property (
		o_output_rate_clock |-> !o_result_ready_n && o_result_ready_n_oe)
		else $error("ready pulse missing at rate tick");
	chk_ready_min_low: assert property (
		$fell(o_result_ready_n) |-> !o_result_ready_n [*8])
		else $error("ready pulse too short");
	chk_ready_end_mod: assert property (
		$rose(o_result_ready_n) |-> o_analog_modulator_clock)
		else $error("ready pulse ends off a modulator tick");
	chk_idle_drive: assert property (
		o_result_ready_n && $past(o_result_ready_n) |->
		o_result_ready_n_oe == $past(i_ready_pin_drive_mode))
		else $error("idle pin drive does not follow mode");
	// a low level must always be driven, never left to the pull-up
	chk_low_driven: assert property (
		!o_result_ready_n |-> o_result_ready_n_oe)
		else $error("ready pin low while not driven");
	chk_result_moves: assert property (
		$changed(o_results) |-> o_output_rate_clock)
		else $error("results changed off a rate tick");
	cov_rate: cover property (o_output_rate_clock);
	cov_pulse_end: cover property ($rose(o_result_ready_n));
	cov_idle_high: cover property (o_result_ready_n_oe && o_result_ready_n);
endmodule // acrd_top_chk

// ==== sim/acrd_host.sv ====
// Purpose: host side watching the ready pin
// Assumes: pin level already resolved with its pull-up
// Notes: counts pulses and keeps the width of the last one
`timescale 1ns/1ps
module acrd_host (
	input wire logic i_clk_sys,
	input wire logic i_pin,
	output int o_pulses,
	output int o_width
);
	logic prev = 1'b1;
	int run = 0;
	// ======================================================================
	// pulse watch; the pulse is not latched, so every cycle is looked at
	always @(posedge i_clk_sys) begin
		if (prev && !i_pin) o_pulses <= o_pulses + 1;
		if (!i_pin) run <= run + 1;
		else begin
			if (!prev) o_width <= run;
			run <= 0;
		end
		prev <= i_pin;
	end
endmodule // acrd_host

// ==== sim/acrd_top_tb.sv ====
// Purpose: self-checking bench of the clock and rate divider
// Assumes: master clocks at 1/8 and 1/12 of the system clock
// Notes: ratios above 512 left out to keep the run short
`timescale 1ns/1ps
module acrd_top_tb;
	import acrd_pkg::*;
	logic clk = 0, rst_n = 0, xtal = 0, ext = 0, src = 0, drv = 0;
	acrd_pre_t pre = 2'h0;
	acrd_osr_t decimation_ratio = 3'h3;
	logic [23:0] smp;
	logic [143:0] off, gain, res;
	logic amc, dsc, rtc, rdy_n, oe, pin;
	int error_cnt = 0, n_checks = 0, cyc, na, nd, pulses, width, p0, r;
	longint x, xe;
	// rows: source, prescale, ratio field, period cycles, pulse width cycles
	int rows[8][5] = '{'{0,0,0,1024,16}, '{1,0,0,1536,24},
		'{0,1,0,2048,32}, '{0,2,0,4096,64}, '{0,3,0,8192,128},
		'{0,0,1,2048,16}, '{0,0,2,4096,16}, '{0,0,3,8192,16}};
	// ======================================================================
	// clocks; master clocks toggle on falling system edges
	always #12.5 clk = ~clk;
	always #100 xtal = ~xtal;
	always #150 ext = ~ext;
	assign pin = oe ? rdy_n : 1'b1;
	acrd_top i_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_crystal_clk(xtal),
		.i_ext_clk(ext), .i_clock_source_external(src),
		.i_prescale_select(pre), .i_oversampling_select(decimation_ratio),
		.i_ready_pin_drive_mode(drv), .i_mod_samples(smp),
		.i_offset_trim_word(off), .i_gain_trim_word(gain), .o_results(res),
		.o_analog_modulator_clock(amc), .o_digital_sample_clock(dsc),
		.o_output_rate_clock(rtc), .o_result_ready_n(rdy_n),
		.o_result_ready_n_oe(oe));
	acrd_host i_host (.i_clk_sys(clk), .i_pin(pin), .o_pulses(pulses),
		.o_width(width));
	// ======================================================================
	// shared tasks
	task automatic chk(string nm, logic signed [47:0] e, s);
		n_checks++;
		if (e !== s) begin
			error_cnt++;
			$display("wrong value %s exp %0d got %0d", nm, e, s);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// bounded wait for a rate tick, counting cycles and ticks on the way
	task automatic wait_rate();
		cyc = 0; na = 0; nd = 0;
		do begin
			@(negedge clk);
			cyc++; na += amc; nd += dsc;
		end while (rtc !== 1'b1 && cyc < 70000);
		if (rtc !== 1'b1) begin
			chk("timeout", 1, 0);
			summarize();
		end
	endtask
	// ======================================================================
	// main sequence
	initial begin
		for (int c = 0; c < 6; c++) begin
			smp[c*4+:4] = 4'(c - 3);
			off[c*24+:24] = 24'(c * 100 - 200);
			gain[c*24+:24] = 24'(c * 1048576);
		end
		repeat (16) @(negedge clk);
		chk("oe in reset", 0, oe);
		chk("rate in reset", 0, rtc);
		rst_n = 1;
		wait_rate();
		chk("first mod ticks", 1024, na);
		$display("test reset done");
		foreach (rows[i]) begin
			@(negedge clk);
			src = rows[i][0];
			pre = 2'(rows[i][1]);
			decimation_ratio = 3'(rows[i][2]);
			wait_rate();
			p0 = pulses;
			wait_rate();
			r = 32 << decimation_ratio;
			chk("period", rows[i][3], cyc);
			chk("mod ticks", 4 * r, na);
			chk("sample ticks", r, nd);
			chk("pulses", 1, pulses - p0);
			chk("pulse width", rows[i][4], width);
			for (int c = 0; c < 6; c++) begin
				x = r * (c - 3) + (c * 100 - 200);
				xe = x + ((x * (c * 1048576)) >>> 23);
				chk("result", xe, $signed(res[c*24+:24]));
			end
			$display("test row %0d done", i);
		end
		// reset in mid-run, with a new setting taken at once
		rst_n = 0;
		decimation_ratio = 3'h4;
		repeat (3) @(negedge clk);
		chk("results in reset", 0, res !== '0);
		rst_n = 1;
		wait_rate();
		chk("restart mod ticks", 2048, na);
		$display("test mid reset done");
		// shorter ratio right after a tick: the next period is exact
		decimation_ratio = 3'h0;
		drv = 1;
		wait_rate();
		chk("short ratio period", 1024, cyc);
		chk("pin low", 0, pin);
		repeat (20) @(negedge clk);
		chk("idle driven", 1, oe && rdy_n);
		drv = 0;
		repeat (2) @(negedge clk);
		chk("idle floats", 0, oe);
		$display("test drive mode done");
		summarize();
	end
endmodule // acrd_top_tb
bind acrd_top acrd_top_chk #(.NCH(NCH)) i_chk (.i_clk_sys, .i_rst_n,
	.i_ready_pin_drive_mode, .o_results, .o_analog_modulator_clock,
	.o_digital_sample_clock, .o_output_rate_clock, .o_result_ready_n,
	.o_result_ready_n_oe);
